// *** logic/rcd_map.vh ***
// command codes, field positions, power-on words, limits and constants for the
// radio configuration command decoder; included by the decoder only.
//
// Behaviour
// - msb first shift while select low
// - match config word, load low byte
// - data register enable; host holds tx pin
// - fifo enable, else data/clock pins
// - band code 01/10/11 selects 433/868/915
// - crystal load 8.5 to 16.0 pF
// - match power word, load enable byte
// - receive enable powers whole receive path
// - baseband enable powers baseband alone
// - tx enable powers synth, osc, pa; transmits if data reg set
// - synth and oscillator enables independent
// - battery monitor and wake timer enables
// - clkout disable stops clock output buffer
// - both tx and rx set gives receive
// - match frequency word, load twelve bits
// - frequency word accepted 96 to 3903
// - centre frequency from band constants
// - match rate word, store prescale, divisor
// - bit rate from divisor and prescale
// - match receiver word, store eleven bits
// - pin function interrupt or valid flag
// - valid flag response, 11 forces on
// - baseband bandwidth code 001 to 110
// - lna gain reduction 0/6/14/20 dB
// - rssi threshold -103 to -73 dBm
`ifndef RCD_MAP_VH
`define RCD_MAP_VH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define RCD_CMD_CFG 8'h80
`define RCD_CMD_PWR 8'h82
`define RCD_CMD_FRQ 4'hA
`define RCD_CMD_RATE 8'hC6
`define RCD_CMD_RX 5'h12

// ------------------------------------------------------------
// power-on words
// ------------------------------------------------------------
`define RCD_POR_CFG 16'h8008
`define RCD_POR_PWR 16'h8208
`define RCD_POR_FRQ 16'hA680
`define RCD_POR_RATE 16'hC623
`define RCD_POR_RX 16'h9080

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RCD_CFG_TXREG 7
`define RCD_CFG_FIFO 6
`define RCD_CFG_BAND_HI 5
`define RCD_CFG_BAND_LO 4
`define RCD_CFG_XTAL_HI 3
`define RCD_PWR_RX 7
`define RCD_PWR_BB 6
`define RCD_PWR_TX 5
`define RCD_PWR_SYN 4
`define RCD_PWR_OSC 3
`define RCD_PWR_BAT 2
`define RCD_PWR_WAKE 1
`define RCD_PWR_CLKDIS 0
`define RCD_RATE_PRESCALE 7
`define RCD_RX_PINFN 10
`define RCD_RX_VDI_HI 9
`define RCD_RX_VDI_LO 8
`define RCD_RX_BW_HI 7
`define RCD_RX_BW_LO 5
`define RCD_RX_LNA_HI 4
`define RCD_RX_LNA_LO 3
`define RCD_RX_RSSI_HI 2

// ------------------------------------------------------------
// limits and constants
// ------------------------------------------------------------
`define RCD_FRQ_MIN 12'h060
`define RCD_FRQ_MAX 12'hF3F
`define RCD_WORD_BITS 5'h10
`define RCD_XTAL_BASE 8'h55
`define RCD_XTAL_STEP 8'h05
`define RCD_RATE_REF_KBPS 10000
`define RCD_RATE_DIV 29
`define RCD_FRQ_DEN 4000

`endif

// *** logic/rcd_decoder.v ***
// serial command decoder holding five radio configuration words and their
// decoded control outputs.
// assumes a host-driven serial clock much slower than mclk (>=25 ns phases
// need mclk period 10 ns; edges are found by oversampling).
`include "rcd_map.vh"

module rcd_decoder (
  mclk,
  reset,
  chip_select_n,
  serial_clk,
  serial_data,
  general_config,
  power_enables,
  synth_frequency,
  bit_rate_setting,
  receiver_setup,
  tx_data_reg_enable,
  rx_fifo_enable,
  data_pins_enable,
  band_select,
  band_valid,
  band_433,
  band_868,
  band_915,
  xtal_load_cap,
  xtal_load_tenths,
  rx_chain_enable,
  baseband_enable,
  tx_chain_enable,
  synth_enable,
  crystal_osc_enable,
  battery_monitor_enable,
  wakeup_timer_enable,
  clkout_disable,
  front_end_on,
  baseband_on,
  synth_on,
  osc_on,
  pa_on,
  transmit_start,
  rx_mode,
  clkout_enable,
  synth_freq_word,
  freq_c1,
  freq_c2,
  rate_divisor,
  rate_prescale_sel,
  rate_total_div,
  pin_function_sel,
  irq_input_sel,
  valid_data_flag_out_sel,
  valid_flag_response,
  valid_flag_forced,
  baseband_bw_sel,
  baseband_bw_khz,
  bw_reserved,
  lna_gain_sel,
  lna_reduction_db,
  rssi_threshold_sel,
  rssi_neg_dbm,
  rssi_reserved,
  ext_tx_data_pin_high_req
);

  input wire mclk;
  input wire reset;
  input wire chip_select_n;
  input wire serial_clk;
  input wire serial_data;
  output wire [15:0] general_config;
  output wire [15:0] power_enables;
  output wire [15:0] synth_frequency;
  output wire [15:0] bit_rate_setting;
  output wire [15:0] receiver_setup;
  output wire tx_data_reg_enable;
  output wire rx_fifo_enable;
  output wire data_pins_enable;
  output wire [1:0] band_select;
  output wire band_valid;
  output wire band_433;
  output wire band_868;
  output wire band_915;
  output wire [3:0] xtal_load_cap;
  output reg [7:0] xtal_load_tenths;
  output wire rx_chain_enable;
  output wire baseband_enable;
  output wire tx_chain_enable;
  output wire synth_enable;
  output wire crystal_osc_enable;
  output wire battery_monitor_enable;
  output wire wakeup_timer_enable;
  output wire clkout_disable;
  output wire front_end_on;
  output wire baseband_on;
  output wire synth_on;
  output wire osc_on;
  output wire pa_on;
  output wire transmit_start;
  output wire rx_mode;
  output wire clkout_enable;
  output wire [11:0] synth_freq_word;
  output reg [1:0] freq_c1;
  output reg [5:0] freq_c2;
  output wire [6:0] rate_divisor;
  output wire rate_prescale_sel;
  output wire [10:0] rate_total_div;
  output wire pin_function_sel;
  output wire irq_input_sel;
  output wire valid_data_flag_out_sel;
  output wire [1:0] valid_flag_response;
  output wire valid_flag_forced;
  output wire [2:0] baseband_bw_sel;
  output reg [8:0] baseband_bw_khz;
  output wire bw_reserved;
  output wire [1:0] lna_gain_sel;
  output reg [4:0] lna_reduction_db;
  output wire [2:0] rssi_threshold_sel;
  output reg [6:0] rssi_neg_dbm;
  output wire rssi_reserved;
  output wire ext_tx_data_pin_high_req;

  // ------------------------------------------------------------
  // pin synchronisers: change counts once stages two and three agree
  // ------------------------------------------------------------
  reg [2:0] sel_sync_q;
  reg [2:0] sck_sync_q;
  reg [2:0] sdi_sync_q;
  reg sel_n_q;
  reg sck_q;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sel_sync_q <= 3'h7;
      sck_sync_q <= 3'h0;
      sdi_sync_q <= 3'h0;
      sel_n_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      sel_sync_q <= {sel_sync_q[1:0], chip_select_n};
      sck_sync_q <= {sck_sync_q[1:0], serial_clk};
      sdi_sync_q <= {sdi_sync_q[1:0], serial_data};
      if (sel_sync_q[1] == sel_sync_q[2])
        sel_n_q <= sel_sync_q[2];
      if (sck_sync_q[1] == sck_sync_q[2])
        sck_q <= sck_sync_q[2];
    end
  end

  wire sck_agree = (sck_sync_q[1] == sck_sync_q[2]);
  wire sck_rise = sck_agree & sck_sync_q[2] & ~sck_q;
  wire sel_rise = (sel_sync_q[1] == sel_sync_q[2]) & sel_sync_q[2] & ~sel_n_q;

  // ------------------------------------------------------------
  // shifter and register file
  // ------------------------------------------------------------
  reg [15:0] shift_q;
  reg [4:0] count_q;
  reg [15:0] cfg_q;
  reg [15:0] pwr_q;
  reg [15:0] frq_q;
  reg [15:0] rate_q;
  reg [15:0] rx_q;

  // a word is exactly sixteen bits; longer bursts belong to other commands
  wire word_full = (count_q == `RCD_WORD_BITS);
  wire frq_ok = (shift_q[11:0] >= `RCD_FRQ_MIN) &&
                (shift_q[11:0] <= `RCD_FRQ_MAX);
  wire commit = sel_rise & word_full;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      cfg_q <= `RCD_POR_CFG;
      pwr_q <= `RCD_POR_PWR;
      frq_q <= `RCD_POR_FRQ;
      rate_q <= `RCD_POR_RATE;
      rx_q <= `RCD_POR_RX;
    end else begin
      if (sel_n_q) begin
        count_q <= 5'h00;
      end else if (sck_rise) begin
        shift_q <= {shift_q[14:0], sdi_sync_q[2]};
        if (count_q != 5'h1F)
          count_q <= count_q + 5'h01;
      end
      if (commit) begin
        if (shift_q[15:8] == `RCD_CMD_CFG)
          cfg_q[7:0] <= shift_q[7:0];
        if (shift_q[15:8] == `RCD_CMD_PWR)
          pwr_q[7:0] <= shift_q[7:0];
        if (shift_q[15:12] == `RCD_CMD_FRQ && frq_ok)
          frq_q[11:0] <= shift_q[11:0];
        if (shift_q[15:8] == `RCD_CMD_RATE)
          rate_q[7:0] <= shift_q[7:0];
        if (shift_q[15:11] == `RCD_CMD_RX)
          rx_q[10:0] <= shift_q[10:0];
      end
    end
  end

  assign general_config = cfg_q;
  assign power_enables = pwr_q;
  assign synth_frequency = frq_q;
  assign bit_rate_setting = rate_q;
  assign receiver_setup = rx_q;

  // ------------------------------------------------------------
  // general configuration
  // ------------------------------------------------------------
  assign tx_data_reg_enable = cfg_q[`RCD_CFG_TXREG];
  assign ext_tx_data_pin_high_req = cfg_q[`RCD_CFG_TXREG];
  assign rx_fifo_enable = cfg_q[`RCD_CFG_FIFO];
  assign data_pins_enable = ~cfg_q[`RCD_CFG_FIFO];
  assign band_select = cfg_q[`RCD_CFG_BAND_HI:`RCD_CFG_BAND_LO];
  assign band_433 = (band_select == 2'h1);
  assign band_868 = (band_select == 2'h2);
  assign band_915 = (band_select == 2'h3);
  assign band_valid = (band_select != 2'h0);
  assign xtal_load_cap = cfg_q[`RCD_CFG_XTAL_HI:0];

  // tenths of a pF keep the half-pF steps in integers
  always @* begin
    xtal_load_tenths = `RCD_XTAL_BASE +
                       ({4'h0, xtal_load_cap} * `RCD_XTAL_STEP);
  end

  // ------------------------------------------------------------
  // power management
  // ------------------------------------------------------------
  assign rx_chain_enable = pwr_q[`RCD_PWR_RX];
  assign baseband_enable = pwr_q[`RCD_PWR_BB];
  assign tx_chain_enable = pwr_q[`RCD_PWR_TX];
  assign synth_enable = pwr_q[`RCD_PWR_SYN];
  assign crystal_osc_enable = pwr_q[`RCD_PWR_OSC];
  assign battery_monitor_enable = pwr_q[`RCD_PWR_BAT];
  assign wakeup_timer_enable = pwr_q[`RCD_PWR_WAKE];
  assign clkout_disable = pwr_q[`RCD_PWR_CLKDIS];
  assign clkout_enable = ~clkout_disable;

  assign rx_mode = rx_chain_enable;
  wire tx_active = tx_chain_enable & ~rx_chain_enable;
  assign front_end_on = rx_chain_enable;
  assign baseband_on = rx_chain_enable | baseband_enable;
  assign synth_on = rx_chain_enable | tx_active | synth_enable;
  assign osc_on = rx_chain_enable | tx_active | crystal_osc_enable;
  assign pa_on = tx_active;
  assign transmit_start = tx_active & tx_data_reg_enable;

  // ------------------------------------------------------------
  // frequency and rate
  // ------------------------------------------------------------
  assign synth_freq_word = frq_q[11:0];

  // f0 = 10*c1*(c2 + word/4000) MHz, evaluated downstream
  always @* begin
    case (band_select)
      2'h1: begin
        freq_c1 = 2'h1;
        freq_c2 = 6'h2B;
      end
      2'h2: begin
        freq_c1 = 2'h2;
        freq_c2 = 6'h2B;
      end
      2'h3: begin
        freq_c1 = 2'h3;
        freq_c2 = 6'h1E;
      end
      default: begin
        freq_c1 = 2'h0;
        freq_c2 = 6'h00;
      end
    endcase
  end

  assign rate_divisor = rate_q[6:0];
  assign rate_prescale_sel = rate_q[`RCD_RATE_PRESCALE];
  // rate = 10000/29/total kbps, total = (divisor+1)*(1+7*prescale)
  assign rate_total_div = rate_prescale_sel ?
    ({3'h0, rate_divisor + 8'h01} << 3) :
    {3'h0, rate_divisor + 8'h01};

  // ------------------------------------------------------------
  // receiver control
  // ------------------------------------------------------------
  assign pin_function_sel = rx_q[`RCD_RX_PINFN];
  assign irq_input_sel = ~pin_function_sel;
  assign valid_data_flag_out_sel = pin_function_sel;
  assign valid_flag_response = rx_q[`RCD_RX_VDI_HI:`RCD_RX_VDI_LO];
  assign valid_flag_forced = (valid_flag_response == 2'h3);
  assign baseband_bw_sel = rx_q[`RCD_RX_BW_HI:`RCD_RX_BW_LO];
  assign lna_gain_sel = rx_q[`RCD_RX_LNA_HI:`RCD_RX_LNA_LO];
  assign rssi_threshold_sel = rx_q[`RCD_RX_RSSI_HI:0];
  assign bw_reserved = (baseband_bw_sel == 3'h0) |
                       (baseband_bw_sel == 3'h7);
  assign rssi_reserved = (rssi_threshold_sel > 3'h5);

  always @* begin
    case (baseband_bw_sel)
      3'h1: baseband_bw_khz = 9'h190;
      3'h2: baseband_bw_khz = 9'h154;
      3'h3: baseband_bw_khz = 9'h10E;
      3'h4: baseband_bw_khz = 9'h0C8;
      3'h5: baseband_bw_khz = 9'h086;
      3'h6: baseband_bw_khz = 9'h043;
      default: baseband_bw_khz = 9'h000;
    endcase
    case (lna_gain_sel)
      2'h0: lna_reduction_db = 5'h00;
      2'h1: lna_reduction_db = 5'h06;
      2'h2: lna_reduction_db = 5'h0E;
      default: lna_reduction_db = 5'h14;
    endcase
    // magnitude of threshold; 0 marks reserved codes
    if (rssi_reserved)
      rssi_neg_dbm = 7'h00;
    else
      rssi_neg_dbm = 7'h67 - ({4'h0, rssi_threshold_sel} * 7'h06);
  end

endmodule

// *** bench/rcd_decoder_chk.sv ***
// concurrent checks on the decoder's decoded outputs and stored words.
// assumes mclk at 100 MHz and an async active-high reset.
module rcd_decoder_chk (
  input wire mclk,
  input wire reset,
  input wire chip_select_n,
  input wire [15:0] general_config,
  input wire rx_fifo_enable,
  input wire data_pins_enable,
  input wire tx_data_reg_enable,
  input wire ext_tx_data_pin_high_req,
  input wire [1:0] band_select,
  input wire band_433,
  input wire band_868,
  input wire band_915,
  input wire [3:0] xtal_load_cap,
  input wire [7:0] xtal_load_tenths,
  input wire rx_chain_enable,
  input wire pa_on,
  input wire front_end_on,
  input wire baseband_on,
  input wire synth_on,
  input wire osc_on,
  input wire [11:0] synth_freq_word,
  input wire [6:0] rate_divisor,
  input wire rate_prescale_sel,
  input wire [10:0] rate_total_div,
  input wire [1:0] valid_flag_response,
  input wire valid_flag_forced
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_FIFO_PINS: assert property (rx_fifo_enable == general_config[6] &&
    data_pins_enable != rx_fifo_enable) else $error("fifo pin select off");
  AST_TXREG: assert property (tx_data_reg_enable == general_config[7] &&
    ext_tx_data_pin_high_req == general_config[7]) else $error("tx reg bad");
  AST_BAND: assert property (band_433 == (band_select == 2'h1) &&
    band_868 == (band_select == 2'h2) && band_915 == (band_select == 2'h3))
    else $error("band decode wrong");
  AST_XTAL: assert property (xtal_load_tenths ==
    8'h55 + 8'h05 * {4'h0, xtal_load_cap}) else $error("xtal load wrong");
  AST_RX_PRIO: assert property (rx_chain_enable |-> !pa_on)
    else $error("transmit while receive set");
  AST_RX_CHAIN: assert property (rx_chain_enable |-> front_end_on &&
    baseband_on && synth_on && osc_on) else $error("receive path off");
  AST_FRQ_RANGE: assert property ($changed(synth_freq_word) |->
    synth_freq_word >= 12'h060 && synth_freq_word <= 12'hF3F)
    else $error("frequency word out of range stored");
  // a commit lands on the fourth mclk edge after select rises, so 6 low cycles is safe
  AST_HOLD: assert property ((!chip_select_n)[*6] |=>
    $stable(general_config)) else $error("word changed mid frame");
  AST_RATE: assert property (rate_total_div == ({4'h0, rate_divisor} +
    11'h001) * (rate_prescale_sel ? 11'h008 : 11'h001))
    else $error("rate divisor wrong");
  AST_VDI: assert property (valid_flag_forced ==
    (valid_flag_response == 2'h3)) else $error("valid flag force wrong");
  COV_FRAME: cover property ((!chip_select_n)[*6]);
  COV_FRQ: cover property ($changed(synth_freq_word));
  COV_FIFO: cover property (rx_fifo_enable && rx_chain_enable);
endmodule

bind rcd_decoder rcd_decoder_chk u_rcd_decoder_chk (.mclk(mclk),
  .reset(reset), .chip_select_n(chip_select_n),
  .general_config(general_config), .rx_fifo_enable(rx_fifo_enable),
  .data_pins_enable(data_pins_enable),
  .tx_data_reg_enable(tx_data_reg_enable),
  .ext_tx_data_pin_high_req(ext_tx_data_pin_high_req),
  .band_select(band_select), .band_433(band_433), .band_868(band_868),
  .band_915(band_915), .xtal_load_cap(xtal_load_cap),
  .xtal_load_tenths(xtal_load_tenths), .rx_chain_enable(rx_chain_enable),
  .pa_on(pa_on), .front_end_on(front_end_on), .baseband_on(baseband_on),
  .synth_on(synth_on), .osc_on(osc_on), .synth_freq_word(synth_freq_word),
  .rate_divisor(rate_divisor), .rate_prescale_sel(rate_prescale_sel),
  .rate_total_div(rate_total_div), .valid_flag_response(valid_flag_response),
  .valid_flag_forced(valid_flag_forced));

// *** bench/rcd_host.sv ***
// host model shifting command words into the decoder.
// assumes the caller starts a word just after an mclk edge.
module rcd_host (
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end
  // n bits of w, top bit first; serial clock idles low outside frames
  task automatic send(input logic [16:0] w, input int n);
    chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    #20 chip_select_n = 1'b1;
    // released data line no longer shows the last bit
    serial_data = ~serial_data;
    #100;
  endtask
endmodule

// *** bench/rcd_decoder_tb.sv ***
// self-checking bench for the command decoder.
// assumes the host model and the bound checker are compiled alongside.
module rcd_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset, chip_select_n, serial_clk, serial_data;
  logic [15:0] general_config, power_enables, synth_frequency;
  logic [15:0] bit_rate_setting, receiver_setup;
  logic tx_data_reg_enable, rx_fifo_enable, data_pins_enable, band_valid;
  logic band_433, band_868, band_915, rx_chain_enable, baseband_enable;
  logic tx_chain_enable, synth_enable, crystal_osc_enable, clkout_disable;
  logic battery_monitor_enable, wakeup_timer_enable, front_end_on;
  logic baseband_on, synth_on, osc_on, pa_on, transmit_start, rx_mode;
  logic clkout_enable, rate_prescale_sel, pin_function_sel, irq_input_sel;
  logic valid_data_flag_out_sel, valid_flag_forced, bw_reserved;
  logic rssi_reserved, ext_tx_data_pin_high_req;
  logic [1:0] band_select, freq_c1, valid_flag_response, lna_gain_sel;
  logic [2:0] baseband_bw_sel, rssi_threshold_sel;
  logic [3:0] xtal_load_cap;
  logic [4:0] lna_reduction_db;
  logic [5:0] freq_c2;
  logic [6:0] rate_divisor, rssi_neg_dbm;
  logic [7:0] xtal_load_tenths;
  logic [8:0] baseband_bw_khz;
  logic [10:0] rate_total_div;
  logic [11:0] synth_freq_word;
  int error_cnt = 0;
  int comparisons = 0;
  logic [15:0] cmd [10] = '{16'h80D7, 16'h82FF, 16'hA060, 16'hA05F,
    16'hAF3F, 16'hAF40, 16'hC6AA, 16'h97FF, 16'h1234, 16'h8220};
  logic [2:0] sel [10] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h4,
    3'h0, 3'h1};
  logic [15:0] expv [10] = '{16'h80D7, 16'h82FF, 16'hA060, 16'hA060,
    16'hAF3F, 16'hAF3F, 16'hC6AA, 16'h97FF, 16'h80D7, 16'h8220};
  logic [1:0] c1e [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [5:0] c2e [4] = '{6'h00, 6'h2B, 6'h2B, 6'h1E};
  // single-bit power words and the power-up outputs each should give
  logic [15:0] pwrw [6] = '{16'h8240, 16'h8210, 16'h8208, 16'h8204,
    16'h8202, 16'h8201};
  logic [7:0] pwre [6] = '{8'h41, 8'h21, 8'h11, 8'h05, 8'h03, 8'h00};
  // receiver field tables: bandwidth khz, lna db, rssi magnitude dbm
  logic [8:0] bwe [8] = '{9'h000, 9'h190, 9'h154, 9'h10E, 9'h0C8, 9'h086,
    9'h043, 9'h000};
  logic [4:0] lnae [4] = '{5'h00, 5'h06, 5'h0E, 5'h14};
  logic [6:0] rse [8] = '{7'h67, 7'h61, 7'h5B, 7'h55, 7'h4F, 7'h49, 7'h00,
    7'h00};
  wire [7:0] pwr_out = {front_end_on, baseband_on, synth_on, osc_on, pa_on,
    battery_monitor_enable, wakeup_timer_enable, clkout_enable};

  rcd_decoder u_rcd_decoder (.*);
  rcd_host u_rcd_host (.chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_data(serial_data));

  always #5 mclk = ~mclk;

  function automatic logic [15:0] word_at(input logic [2:0] s);
    case (s)
      3'h0: return general_config;
      3'h1: return power_enables;
      3'h2: return synth_frequency;
      3'h3: return bit_rate_setting;
      default: return receiver_setup;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the commit lands about 4 cycles after select rises; 10 leaves margin
  task automatic cmd_send(input logic [16:0] w, input int n);
    @(posedge mclk) #1;
    u_rcd_host.send(w, n);
    repeat (10) @(posedge mclk);
  endtask

  task automatic check_defaults();
    check(general_config, 16'h8008);
    check(power_enables, 16'h8208);
    check(synth_frequency, 16'hA680);
    check(bit_rate_setting, 16'hC623);
    check(receiver_setup, 16'h9080);
  endtask

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    repeat (6) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (4) @(posedge mclk);
    check_defaults();
    // ------------------------------------------------------------
    // table of ordinary words, out-of-range and unmatched among them
    // ------------------------------------------------------------
    for (int i = 0; i < 10; i++) begin
      cmd_send({1'b0, cmd[i]}, 16);
      check(word_at(sel[i]), expv[i]);
    end
    check(16'(transmit_start), 16'h0001);
    check(16'(data_pins_enable), 16'h0000);
    check(16'(rate_total_div), 16'h0158);
    cmd_send({1'b0, 16'h82A0}, 16);
    check(16'({pa_on, rx_mode}), 16'h0001);
    // partial and overlong words are dropped
    cmd_send({1'b0, 16'h8000}, 15);
    check(general_config, 16'h80D7);
    cmd_send({1'b1, 16'h8000}, 17);
    check(general_config, 16'h80D7);
    for (int i = 0; i < 4; i++) begin
      cmd_send({1'b0, 8'h80, 2'h0, i[1:0], 4'h0}, 16);
      check(16'(freq_c1), 16'(c1e[i]));
      check(16'(freq_c2), 16'(c2e[i]));
      check(16'(band_valid), 16'(i != 0));
      cmd_send({1'b0, 6'h24, i[1:0], 8'h00}, 16);
      check(16'(valid_flag_forced), 16'(i == 3));
      check(16'({irq_input_sel, valid_data_flag_out_sel}), 16'h0002);
    end
    // ------------------------------------------------------------
    // power bits one at a time, then receiver field codes
    // ------------------------------------------------------------
    for (int i = 0; i < 6; i++) begin
      cmd_send({1'b0, pwrw[i]}, 16);
      check(16'(pwr_out), 16'(pwre[i]));
    end
    for (int i = 0; i < 8; i++) begin
      cmd_send({1'b0, 5'h12, 3'h4, i[2:0], i[1:0], i[2:0]}, 16);
      check(16'(baseband_bw_khz), 16'(bwe[i]));
      check(16'(bw_reserved), 16'(i == 0 || i == 7));
      check(16'(lna_reduction_db), 16'(lnae[i[1:0]]));
      check(16'(rssi_neg_dbm), 16'(rse[i]));
      check(16'(rssi_reserved), 16'(i > 5));
      check(16'({irq_input_sel, valid_data_flag_out_sel}), 16'h0001);
    end
    @(posedge mclk) #1 reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (4) @(posedge mclk);
    check_defaults();
    complete_run();
  end
endmodule
